// ==== ptp_bus_pkg.sv ====
// Shared constants and types for the endpoint bus slave and its bus master
package ptp_bus_pkg;

   // ************************************************************
   // Bus shape
   // ************************************************************
   localparam int DATA_W      = 32;
   localparam int ADDR_W      = 32;
   localparam int BE_W        = 4;
   localparam int BYTE_W      = 8;
   localparam int NUM_MASTERS = 1;

   // ************************************************************
   // Address map (byte addresses, one byte per address value)
   // ************************************************************
   // Base of the endpoint window; arbitrary placement
   localparam logic [31:0] BASE_ADDR     = 32'h8000_0000;
   localparam logic [31:0] SPACE_MASK    = 32'hFFFF_C000;
   localparam int          OFS_W         = 14;
   localparam logic [13:0] MEM_END_OFS   = 14'h0100;
   localparam int          MEM_WORDS     = 64;
   localparam int          MEM_AW        = 6;
   localparam int          WORD_LSB      = 2;
   localparam logic [13:0] TX_CTRL_OFS   = 14'h2000;
   localparam logic [13:0] RX_CTRL_OFS   = 14'h2004;
   localparam logic [13:0] TIMER_ACK_OFS = 14'h2040;

   // ************************************************************
   // Register fields
   // ************************************************************
   localparam int TX_SEND_LSB  = 0;
   localparam int TX_SEND_W    = 8;
   localparam int TX_NUM_LSB   = 16;
   localparam int TX_NUM_W     = 3;
   localparam int RX_CLEAR_BIT = 0;
   localparam int RX_NUM_LSB   = 8;
   localparam int RX_NUM_W     = 4;

   // ************************************************************
   // Transfer qualifiers
   // ************************************************************
   localparam logic [3:0] SIZE_SINGLE = 4'h0;
   localparam logic [2:0] TYPE_MEMORY = 3'h0;
   localparam logic [1:0] SSIZE_32    = 2'h1;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam longint TICK_NS       = 64'd7812500;
   localparam longint CLK_PERIOD_NS = 64'd40;
   localparam int     TICK_CYCLES   = int'(TICK_NS / CLK_PERIOD_NS);
   localparam int     TICK_W        = 18;

   // ************************************************************
   // State encodings
   // ************************************************************
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_WAIT = 4'b0010,
      ST_ACK  = 4'b0100,
      ST_DATA = 4'b1000
   } slave_state_t;

   typedef enum logic [2:0] {
      H_IDLE = 3'b001,
      H_ADDR = 3'b010,
      H_DATA = 3'b100
   } master_state_t;

endpackage

// ==== ptp_bus_if.sv ====
// Local bus connection between one bus master and the endpoint slave
`timescale 1ns/1ps
`default_nettype none
interface ptp_bus_if;
   import ptp_bus_pkg::*;

   // Master to slave
   logic [31:0]            abus;
   logic                   pa_valid;
   logic                   rnw;
   logic [3:0]             be;
   logic [3:0]             size;
   logic [2:0]             ttype;
   logic [1:0]             msize;
   logic [0:0]             master_id;
   logic [31:0]            wr_dbus;
   logic                   abort;
   logic                   rd_burst;
   logic                   wr_burst;
   logic                   sa_valid;
   logic                   bus_lock;
   logic [15:0]            t_attribute;
   // Slave to master
   logic                   addr_ack;
   logic [1:0]             ssize;
   logic                   sl_wait;
   logic                   rearbitrate;
   logic                   wr_dack;
   logic                   wr_comp;
   logic                   wr_bterm;
   logic [31:0]            rd_dbus;
   logic [3:0]             rd_wd_addr;
   logic                   rd_dack;
   logic                   rd_comp;
   logic                   rd_bterm;
   logic [NUM_MASTERS-1:0] mbusy;
   logic [NUM_MASTERS-1:0] mwr_err;
   logic [NUM_MASTERS-1:0] mrd_err;
   logic [NUM_MASTERS-1:0] mirq;
   // Interrupts to the processor
   logic                   irq_timer;
   logic                   irq_tx;
   logic                   irq_rx;

   modport slave (
      input  abus, pa_valid, rnw, be, size, ttype, msize, master_id, wr_dbus, abort,
      input  rd_burst, wr_burst, sa_valid, bus_lock, t_attribute,
      output addr_ack, ssize, sl_wait, rearbitrate, wr_dack, wr_comp, wr_bterm,
      output rd_dbus, rd_wd_addr, rd_dack, rd_comp, rd_bterm,
      output mbusy, mwr_err, mrd_err, mirq, irq_timer, irq_tx, irq_rx
   );

   modport master (
      output abus, pa_valid, rnw, be, size, ttype, msize, master_id, wr_dbus, abort,
      output rd_burst, wr_burst, sa_valid, bus_lock, t_attribute,
      input  addr_ack, ssize, sl_wait, rearbitrate, wr_dack, wr_comp, wr_bterm,
      input  rd_dbus, rd_wd_addr, rd_dack, rd_comp, rd_bterm,
      input  mbusy, mwr_err, mrd_err, mirq, irq_timer, irq_tx, irq_rx
   );
endinterface
`default_nettype wire

// ==== ptp_endpoint_bus_slave.sv ====
// Endpoint bus slave: single-beat register and buffer access plus interrupts
// Operation
// - Simple slave, 32-bit read and write data.
// - Single-beat transfers only, no bursts.
// - Master presents transfer size code zero.
// - Master presents transfer type code zero.
// - Ignore unused inputs, tie unused outputs constant.
// - Rearbitrate, errors, per-master interrupts held zero.
// - Address phase stretched with wait, late ack.
// - Read data acknowledge delayed until data ready.
// - Write data acknowledge delayed until data sampled.
// - Everything synchronous to bus clock, synchronous reset.
// - Interrupts active high, raised by hardware.
// - Interrupt holds until its register is accessed.
// - Timer interrupt every 1/128 second.
// - Transmit interrupt after packet sent.
// - Receive interrupt after packet stored.
// - Interrupts should reach an interrupt controller.
// - Each address value selects one byte.
// - Packet control access clears matching interrupt.
`timescale 1ns/1ps
`default_nettype none
module ptp_endpoint_bus_slave
   import ptp_bus_pkg::*;
#(
   parameter int TICK_COUNT = TICK_CYCLES
)(
   input  wire logic                  SYS_CLK,
   input  wire logic                  RESETN,
   ptp_bus_if.slave                   BUS,
   input  wire logic                  TX_SENT,
   input  wire logic [TX_NUM_W-1:0]   TX_NUM,
   input  wire logic                  RX_STORED,
   input  wire logic [RX_NUM_W-1:0]   RX_NUM,
   output var  logic [TX_SEND_W-1:0]  TX_SEND_REQ,
   output var  logic                  RX_CLEAR
);

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      slave_state_t                      state;
      logic                              sl_wait;
      logic                              addr_ack;
      logic                              busy;
      logic                              rnw;
      logic [OFS_W-1:0]                  ofs;
      logic [BE_W-1:0]                   be;
      logic                              rd_dack;
      logic                              wr_dack;
      logic [DATA_W-1:0]                 rd_dbus;
      logic [TICK_W-1:0]                 tick_cnt;
      logic                              irq_timer;
      logic                              irq_tx;
      logic                              irq_rx;
      logic [TX_NUM_W-1:0]               tx_num;
      logic [RX_NUM_W-1:0]               rx_num;
      logic [TX_SEND_W-1:0]              tx_send;
      logic                              rx_clear;
      logic [MEM_WORDS-1:0][DATA_W-1:0]  mem;
   } slave_regs_t;

   slave_regs_t r;
   slave_regs_t next_r;

   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_COUNT - 1);

   // ************************************************************
   // Next-state logic
   // ************************************************************
   always_comb begin
      logic              hit;
      logic              tick;
      logic              clr_tx;
      logic              clr_rx;
      logic              clr_timer;
      logic [MEM_AW-1:0] idx;
      logic [DATA_W-1:0] rd_word;
      hit       = 1'b0;
      tick      = 1'b0;
      clr_tx    = 1'b0;
      clr_rx    = 1'b0;
      clr_timer = 1'b0;
      idx       = r.ofs[WORD_LSB +: MEM_AW];
      rd_word   = '0;
      next_r    = r;

      // Pulses last one cycle; read bus idles at zero
      next_r.addr_ack = 1'b0;
      next_r.rd_dack  = 1'b0;
      next_r.wr_dack  = 1'b0;
      next_r.rd_dbus  = '0;
      next_r.tx_send  = '0;
      next_r.rx_clear = 1'b0;

      // Free-running tick counter paces the timer interrupt
      tick = (r.tick_cnt == TICK_LAST);
      next_r.tick_cnt = tick ? '0 : r.tick_cnt + TICK_W'(1);

      // Only size and type zero are claimed; other codes are left unanswered
      hit = ((BUS.abus & SPACE_MASK) == BASE_ADDR)
            && (BUS.size == SIZE_SINGLE)
            && (BUS.ttype == TYPE_MEMORY);

      // Read word: buffer words, then status fields, else zero
      if (r.ofs < MEM_END_OFS) begin
         rd_word = r.mem[idx];
      end else if (r.ofs[OFS_W-1:WORD_LSB] == TX_CTRL_OFS[OFS_W-1:WORD_LSB]) begin
         rd_word[TX_NUM_LSB +: TX_NUM_W] = r.tx_num;
      end else if (r.ofs[OFS_W-1:WORD_LSB] == RX_CTRL_OFS[OFS_W-1:WORD_LSB]) begin
         rd_word[RX_NUM_LSB +: RX_NUM_W] = r.rx_num;
      end

      // Transfer sequencer; burst, lock and attribute inputs are never looked at
      unique case (r.state)
         ST_IDLE: begin
            if (BUS.pa_valid && hit) begin
               next_r.state   = ST_WAIT;
               next_r.sl_wait = 1'b1;
               next_r.busy    = 1'b1;
               next_r.rnw     = BUS.rnw;
               next_r.ofs     = BUS.abus[OFS_W-1:0];
               next_r.be      = BUS.be;
            end
         end
         ST_WAIT: begin
            next_r.sl_wait = 1'b0;
            if (BUS.abort) begin
               next_r.state = ST_IDLE;
               next_r.busy  = 1'b0;
            end else begin
               next_r.state    = ST_ACK;
               next_r.addr_ack = 1'b1;
            end
         end
         ST_ACK: begin
            next_r.state = ST_DATA;
            if (r.rnw) begin
               next_r.rd_dack = 1'b1;
               next_r.rd_dbus = rd_word;
            end else begin
               next_r.wr_dack = 1'b1;
               if (r.ofs < MEM_END_OFS) begin
                  for (int i = 0; i < BE_W; i++) begin
                     if (r.be[i]) begin
                        next_r.mem[idx][i*BYTE_W +: BYTE_W] =
                           BUS.wr_dbus[i*BYTE_W +: BYTE_W];
                     end
                  end
               end else if (r.ofs[OFS_W-1:WORD_LSB] == TX_CTRL_OFS[OFS_W-1:WORD_LSB]) begin
                  next_r.tx_send = BUS.wr_dbus[TX_SEND_LSB +: TX_SEND_W];
               end else if (r.ofs[OFS_W-1:WORD_LSB] == RX_CTRL_OFS[OFS_W-1:WORD_LSB]) begin
                  next_r.rx_clear = BUS.wr_dbus[RX_CLEAR_BIT];
               end
            end
            // Any access, read or write, acknowledges the interrupt
            clr_tx    = (r.ofs[OFS_W-1:WORD_LSB] == TX_CTRL_OFS[OFS_W-1:WORD_LSB]);
            clr_rx    = (r.ofs[OFS_W-1:WORD_LSB] == RX_CTRL_OFS[OFS_W-1:WORD_LSB]);
            clr_timer = (r.ofs[OFS_W-1:WORD_LSB] == TIMER_ACK_OFS[OFS_W-1:WORD_LSB]);
         end
         ST_DATA: begin
            next_r.state = ST_IDLE;
            next_r.busy  = 1'b0;
         end
      endcase

      // Latest packet numbers for software
      if (TX_SENT) begin
         next_r.tx_num = TX_NUM;
      end
      if (RX_STORED) begin
         next_r.rx_num = RX_NUM;
      end

      // Sticky interrupts; a new event beats a clear in the same cycle
      next_r.irq_timer = (r.irq_timer & ~clr_timer) | tick;
      next_r.irq_tx    = (r.irq_tx & ~clr_tx) | TX_SENT;
      next_r.irq_rx    = (r.irq_rx & ~clr_rx) | RX_STORED;
   end

   // ************************************************************
   // State register
   // ************************************************************
   // Synchronous reset; the buffer is cleared too so reads are defined
   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         r       <= '0;
         r.state <= ST_IDLE;
      end else begin
         r <= next_r;
      end
   end

   // ************************************************************
   // Bus outputs
   // ************************************************************
   // Completion coincides with the data acknowledge for single beats
   assign BUS.addr_ack   = r.addr_ack;
   assign BUS.sl_wait    = r.sl_wait;
   assign BUS.rd_dack    = r.rd_dack;
   assign BUS.rd_comp    = r.rd_dack;
   assign BUS.rd_dbus    = r.rd_dbus;
   assign BUS.wr_dack    = r.wr_dack;
   assign BUS.wr_comp    = r.wr_dack;
   assign BUS.mbusy      = {NUM_MASTERS{r.busy}};

   // Fixed outputs
   assign BUS.ssize       = SSIZE_32;
   assign BUS.rd_wd_addr  = '0;
   assign BUS.rd_bterm    = 1'b0;
   assign BUS.wr_bterm    = 1'b0;
   assign BUS.rearbitrate = 1'b0;
   assign BUS.mwr_err     = '0;
   assign BUS.mrd_err     = '0;
   assign BUS.mirq        = '0;

   // Interrupts to the processor
   assign BUS.irq_timer  = r.irq_timer;
   assign BUS.irq_tx     = r.irq_tx;
   assign BUS.irq_rx     = r.irq_rx;

   // User side
   assign TX_SEND_REQ    = r.tx_send;
   assign RX_CLEAR       = r.rx_clear;

endmodule
`default_nettype wire

// ==== ptp_bus_master.sv ====
// Bus master end: turns user commands into single-beat transfers
`timescale 1ns/1ps
`default_nettype none
module ptp_bus_master
   import ptp_bus_pkg::*;
(
   input  wire logic               SYS_CLK,
   input  wire logic               RESETN,
   ptp_bus_if.master               BUS,
   input  wire logic               CMD_VALID,
   input  wire logic               CMD_RNW,
   input  wire logic [ADDR_W-1:0]  CMD_ADDR,
   input  wire logic [BE_W-1:0]    CMD_BE,
   input  wire logic [DATA_W-1:0]  CMD_WDATA,
   output var  logic               CMD_READY,
   output var  logic               RSP_VALID,
   output var  logic [DATA_W-1:0]  RSP_RDATA,
   output var  logic               IRQ_TIMER,
   output var  logic               IRQ_TX,
   output var  logic               IRQ_RX
);

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      master_state_t      state;
      logic               pa_valid;
      logic               rnw;
      logic [ADDR_W-1:0]  addr;
      logic [BE_W-1:0]    be;
      logic [DATA_W-1:0]  wdata;
      logic               ready;
      logic               rsp_valid;
      logic [DATA_W-1:0]  rsp_rdata;
      logic               irq_timer;
      logic               irq_tx;
      logic               irq_rx;
   } master_regs_t;

   master_regs_t r;
   master_regs_t next_r;

   // ************************************************************
   // Next-state logic
   // ************************************************************
   always_comb begin
      next_r           = r;
      next_r.rsp_valid = 1'b0;
      // Interrupt copies keep the user outputs registered
      next_r.irq_timer = BUS.irq_timer;
      next_r.irq_tx    = BUS.irq_tx;
      next_r.irq_rx    = BUS.irq_rx;

      // One transfer in flight; no burst is ever requested
      unique case (r.state)
         H_IDLE: begin
            if (CMD_VALID) begin
               next_r.state    = H_ADDR;
               next_r.pa_valid = 1'b1;
               next_r.ready    = 1'b0;
               next_r.rnw      = CMD_RNW;
               next_r.addr     = CMD_ADDR;
               next_r.be       = CMD_BE;
               next_r.wdata    = CMD_WDATA;
            end
         end
         H_ADDR: begin
            // Request held through any wait until the slave acknowledges
            if (BUS.addr_ack) begin
               next_r.state    = H_DATA;
               next_r.pa_valid = 1'b0;
            end
         end
         H_DATA: begin
            if ((r.rnw && BUS.rd_dack) || (!r.rnw && BUS.wr_dack)) begin
               next_r.state     = H_IDLE;
               next_r.ready     = 1'b1;
               next_r.rsp_valid = 1'b1;
               next_r.rsp_rdata = r.rnw ? BUS.rd_dbus : '0;
            end
         end
      endcase
   end

   // ************************************************************
   // State register
   // ************************************************************
   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         r       <= '0;
         r.state <= H_IDLE;
         r.ready <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   // ************************************************************
   // Bus outputs
   // ************************************************************
   assign BUS.abus        = r.addr;
   assign BUS.pa_valid    = r.pa_valid;
   assign BUS.rnw         = r.rnw;
   assign BUS.be          = r.be;
   assign BUS.wr_dbus     = r.wdata;
   assign BUS.size        = SIZE_SINGLE;
   assign BUS.ttype       = TYPE_MEMORY;
   assign BUS.msize       = SSIZE_32;
   assign BUS.master_id   = '0;
   assign BUS.abort       = 1'b0;
   assign BUS.rd_burst    = 1'b0;
   assign BUS.wr_burst    = 1'b0;
   assign BUS.sa_valid    = 1'b0;
   assign BUS.bus_lock    = 1'b0;
   assign BUS.t_attribute = '0;

   // User side; interrupts go on to the interrupt controller
   assign CMD_READY = r.ready;
   assign RSP_VALID = r.rsp_valid;
   assign RSP_RDATA = r.rsp_rdata;
   assign IRQ_TIMER = r.irq_timer;
   assign IRQ_TX    = r.irq_tx;
   assign IRQ_RX    = r.irq_rx;

endmodule
`default_nettype wire

// ==== ptp_bus_monitor.sv ====
// Concurrent checks on the bus between the master end and the endpoint slave
`timescale 1ns/1ps
`default_nettype none
module ptp_bus_monitor
   import ptp_bus_pkg::*;
#(
   parameter int TICK_COUNT = TICK_CYCLES
)(
   input wire logic                   SYS_CLK,
   input wire logic                   RESETN,
   input wire logic [31:0]            abus,
   input wire logic                   pa_valid,
   input wire logic                   rnw,
   input wire logic                   addr_ack,
   input wire logic                   sl_wait,
   input wire logic                   mbusy,
   input wire logic                   rd_dack,
   input wire logic                   rd_comp,
   input wire logic                   wr_dack,
   input wire logic                   wr_comp,
   input wire logic [31:0]            rd_dbus,
   input wire logic [1:0]             ssize,
   input wire logic                   rearbitrate,
   input wire logic                   wr_bterm,
   input wire logic                   rd_bterm,
   input wire logic [3:0]             rd_wd_addr,
   input wire logic [NUM_MASTERS-1:0] mwr_err,
   input wire logic [NUM_MASTERS-1:0] mrd_err,
   input wire logic [NUM_MASTERS-1:0] mirq,
   input wire logic                   irq_timer,
   input wire logic                   irq_tx,
   input wire logic                   irq_rx
);
   // ************************************************************
   // Helper logic
   // ************************************************************
   logic [TICK_W-1:0] tick;

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RESETN);

   // Shadow tick counter, restarted by reset just like the slave's
   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         tick <= '0;
      end else begin
         tick <= (tick == TICK_W'(TICK_COUNT - 1)) ? '0 : tick + TICK_W'(1);
      end
   end

   // ************************************************************
   // Properties
   // ************************************************************
   sequence s_take;
      $rose(pa_valid) && ((abus & SPACE_MASK) == BASE_ADDR);
   endsequence
   sequence s_addr;
      sl_wait && mbusy ##1 addr_ack && !sl_wait;
   endsequence

   a_addr_phase: assert property (s_take |=> s_addr)
      else $error("address phase out of order");
   a_ack_held: assert property (addr_ack |-> pa_valid && mbusy)
      else $error("address ack without request");
   a_read_ack: assert property (addr_ack && rnw |=> rd_dack && rd_comp && !wr_dack)
      else $error("read data ack missing");
   a_write_ack: assert property (addr_ack && !rnw |=> wr_dack && wr_comp && !rd_dack)
      else $error("write data ack missing");
   a_rdbus_quiet: assert property (!rd_dack |-> rd_dbus == '0)
      else $error("read bus driven outside ack");
   a_single_beat: assert property (rd_dack || wr_dack |=> !rd_dack && !wr_dack)
      else $error("second data beat");
   a_tied_out: assert property (!rearbitrate && !wr_bterm && !rd_bterm && mwr_err == '0
      && mrd_err == '0 && mirq == '0 && ssize == SSIZE_32 && rd_wd_addr == '0)
      else $error("constant output moved");
   a_busy_end: assert property (rd_dack || wr_dack |=> !mbusy)
      else $error("slave still busy after single beat");
   a_tx_clear: assert property ($fell(irq_tx) |-> rd_dack || wr_dack)
      else $error("tx interrupt dropped without access");
   a_rx_clear: assert property ($fell(irq_rx) |-> rd_dack || wr_dack)
      else $error("rx interrupt dropped without access");
   a_timer_clear: assert property ($fell(irq_timer) |-> rd_dack || wr_dack)
      else $error("timer interrupt dropped without access");
   a_timer_tick: assert property ($rose(irq_timer) |-> tick == '0)
      else $error("timer interrupt off its period");
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench: master and endpoint slave joined by the bus interface
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import ptp_bus_pkg::*;
;
   // Short tick so the timer period fits the run
   localparam int TICKS = 20;
   localparam int LIMIT = 3000;
   logic        sys_clk, resetn, cmd_valid, cmd_rnw, cmd_ready, rsp_valid;
   logic        irq_timer, irq_tx, irq_rx, tx_sent, rx_stored, rx_clear, seen_clear;
   logic [31:0] cmd_addr, cmd_wdata, rsp_rdata, rdata;
   logic [3:0]  cmd_be, rx_num;
   logic [2:0]  tx_num;
   logic [7:0]  tx_send_req, seen_req;
   int          num_errors, tests_run, cycles;

   ptp_bus_if bus ();
   ptp_endpoint_bus_slave #(.TICK_COUNT(TICKS)) i_ptp_endpoint_bus_slave (
      .SYS_CLK(sys_clk), .RESETN(resetn), .BUS(bus), .TX_SENT(tx_sent), .TX_NUM(tx_num),
      .RX_STORED(rx_stored), .RX_NUM(rx_num), .TX_SEND_REQ(tx_send_req), .RX_CLEAR(rx_clear));
   ptp_bus_master i_ptp_bus_master (
      .SYS_CLK(sys_clk), .RESETN(resetn), .BUS(bus), .CMD_VALID(cmd_valid), .CMD_RNW(cmd_rnw),
      .CMD_ADDR(cmd_addr), .CMD_BE(cmd_be), .CMD_WDATA(cmd_wdata), .CMD_READY(cmd_ready),
      .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata), .IRQ_TIMER(irq_timer), .IRQ_TX(irq_tx),
      .IRQ_RX(irq_rx));
   ptp_bus_monitor #(.TICK_COUNT(TICKS)) i_ptp_bus_monitor (
      .SYS_CLK(sys_clk), .RESETN(resetn), .abus(bus.abus), .pa_valid(bus.pa_valid),
      .rnw(bus.rnw), .addr_ack(bus.addr_ack), .sl_wait(bus.sl_wait), .mbusy(bus.mbusy),
      .rd_dack(bus.rd_dack), .rd_comp(bus.rd_comp), .wr_dack(bus.wr_dack),
      .wr_comp(bus.wr_comp), .rd_dbus(bus.rd_dbus), .ssize(bus.ssize),
      .rearbitrate(bus.rearbitrate), .wr_bterm(bus.wr_bterm), .rd_bterm(bus.rd_bterm),
      .rd_wd_addr(bus.rd_wd_addr),
      .mwr_err(bus.mwr_err), .mrd_err(bus.mrd_err), .mirq(bus.mirq),
      .irq_timer(bus.irq_timer), .irq_tx(bus.irq_tx), .irq_rx(bus.irq_rx));

   // ************************************************************
   // Clock, pulse capture and hang guard
   // ************************************************************
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   // Strobes last one cycle, so latch them for later comparison
   always @(posedge sys_clk) begin
      cycles++;
      if (tx_send_req != 8'h00) seen_req <= tx_send_req;
      if (rx_clear === 1'b1) seen_clear <= 1'b1;
      if (cycles == LIMIT) begin
         num_errors++;
         finish_test;
      end
   end

   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic tick;
      @(posedge sys_clk);
      #1;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH at %0t: seen %08h expected %08h", $time, seen, exp);
      end
   endtask
   // One command held until taken; reply must come four edges later
   task automatic xfer(input logic rnw, input logic [13:0] ofs, input logic [3:0] be,
                       input logic [31:0] wdata);
      int n;
      n = 0;
      cmd_valid = 1'b1;
      cmd_rnw = rnw;
      cmd_addr = BASE_ADDR | 32'(ofs);
      cmd_be = be;
      cmd_wdata = wdata;
      while (cmd_ready !== 1'b1) tick;
      tick;
      cmd_valid = 1'b0;
      while (rsp_valid !== 1'b1 && n < 10) begin
         tick;
         n++;
      end
      check(n, 4);
      rdata = rsp_rdata;
   endtask
   task automatic finish_test;
      $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   // Partial write must keep the unselected lanes; neighbour word untouched
   task automatic t_mem;
      xfer(1'b0, 14'h0010, 4'hF, 32'h1122_3344);
      xfer(1'b0, 14'h0014, 4'hF, 32'hCAFE_F00D);
      xfer(1'b0, 14'h0010, 4'h5, 32'hAABB_CCDD);
      xfer(1'b1, 14'h0010, 4'hF, 32'h0);
      check(rdata, 32'h11BB_33DD);
      xfer(1'b1, 14'h0014, 4'hF, 32'h0);
      check(rdata, 32'hCAFE_F00D);
      // Unmapped offsets inside the window drop writes and read back zero
      xfer(1'b0, 14'h0200, 4'hF, 32'h5A5A_5A5A);
      xfer(1'b1, 14'h0200, 4'hF, 32'h0);
      check(rdata, 32'h0000_0000);
      $display("Test mem done");
   endtask
   // Sent packet raises the line, it holds, a read clears it
   task automatic t_tx;
      tx_num = 3'h5;
      tx_sent = 1'b1;
      tick;
      tx_sent = 1'b0;
      tick;
      check(irq_tx, 1'b1);
      repeat (10) tick;
      check(irq_tx, 1'b1);
      xfer(1'b1, TX_CTRL_OFS, 4'hF, 32'h0);
      check(rdata, 32'h0005_0000);
      check(irq_tx, 1'b0);
      xfer(1'b0, TX_CTRL_OFS, 4'hF, 32'h0000_00A5);
      check(seen_req, 8'hA5);
      $display("Test tx done");
   endtask
   // Stored packet raises the line, a write clears it
   task automatic t_rx;
      rx_num = 4'h9;
      rx_stored = 1'b1;
      tick;
      rx_stored = 1'b0;
      tick;
      check(irq_rx, 1'b1);
      xfer(1'b0, RX_CTRL_OFS, 4'hF, 32'h0000_0001);
      check(irq_rx, 1'b0);
      check(seen_clear, 1'b1);
      xfer(1'b1, RX_CTRL_OFS, 4'hF, 32'h0);
      check(rdata, 32'h0000_0900);
      $display("Test rx done");
   endtask
   // Spacing of two timer rises, cleared in between, is one tick period
   task automatic t_timer;
      int n;
      n = 0;
      xfer(1'b1, TIMER_ACK_OFS, 4'hF, 32'h0);
      check(rdata, 32'h0000_0000);
      while (irq_timer !== 1'b1 && n < 50) begin
         tick;
         n++;
      end
      xfer(1'b1, TIMER_ACK_OFS, 4'hF, 32'h0);
      n = 5;
      while (irq_timer !== 1'b1 && n < 50) begin
         tick;
         n++;
      end
      check(n, TICKS);
      $display("Test timer done");
   endtask

   initial begin
      {resetn, cmd_valid, cmd_rnw, tx_sent, rx_stored, seen_clear} = '0;
      {cmd_addr, cmd_wdata, cmd_be, rx_num, tx_num, seen_req} = '0;
      num_errors = 0;
      tests_run = 0;
      cycles = 0;
      repeat (16) tick;
      resetn = 1'b1;
      tick;
      t_mem;
      t_tx;
      t_rx;
      t_timer;
      finish_test;
   end
endmodule
`default_nettype wire
